// file: logic/dstcv_top.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - seasonal conversion is disabled after reset until software enables it.
// - europe: forward 60 min at 02:00 last Sunday March, back 03:00 October.
// - britain: forward at 01:00 last Sunday March, back 02:00 last October.
// - old america: forward 02:00 first Sunday April, back 02:00 last October.
// - new america: forward 02:00 second Sunday March, back first November.
// - australia: forward 02:00 last Sunday October, back 03:00 last March.
// - tasmania: forward 02:00 first Sunday October, back 03:00 last March.
// - new zealand: forward 02:00 first Sunday October, back third Sunday March.
// - user rule: forward by delta 02:00 start date, back 03:00 end date.
// - user delta accepted only in whole minutes from 0 to 180.
// - conversion only while powered in RUN or STOP, never on backup.
// - with sync enabled, time from the communication module loads the clock.
// - time broadcast at power-up, hourly while powered (not on backup), after manual set or conversion.
// - time synchronisation is disabled after reset.
// - enables and rule selection change in programming or parameter mode.
module dstcv_top #(
  parameter int unsigned TICKS_PER_MIN = 32'(dstcv_pkg::TICKS_PER_MIN)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic op_active,
  input wire logic cfg_allowed,
  input wire logic sync_valid,
  input wire logic [6:0] sync_year,
  input wire logic [3:0] sync_month,
  input wire logic [4:0] sync_day,
  input wire logic [2:0] sync_wday,
  input wire logic [4:0] sync_hour,
  input wire logic [5:0] sync_minute,
  output logic bcast_valid,
  output logic [6:0] bcast_year,
  output logic [3:0] bcast_month,
  output logic [4:0] bcast_day,
  output logic [2:0] bcast_wday,
  output logic [4:0] bcast_hour,
  output logic [5:0] bcast_minute,
  output logic summer_active
);

  if (TICKS_PER_MIN < 2) begin : g_bad_ticks
    $error("dstcv_top: TICKS_PER_MIN must be at least 2");
  end

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic conv_en;
    dstcv_pkg::dstcv_preset_t preset;
    logic sync_en;
    logic [3:0] us_month;
    logic [4:0] us_day;
    logic [3:0] ue_month;
    logic [4:0] ue_day;
    logic [7:0] delta;
    logic summer;
    logic [31:0] presc;
    dstcv_pkg::dstcv_time_t t;
    logic booted;
    logic bcast;
    dstcv_pkg::dstcv_time_t bt;
  } dstcv_state_t;

  dstcv_state_t s_reg;
  dstcv_state_t s_next;

  function automatic logic [4:0] days_in(input logic [3:0] m,
                                         input logic [6:0] y);
    case (m)
      4'h2: days_in = (y[1:0] == 2'h0) ? 5'h1d : 5'h1c;
      4'h4, 4'h6, 4'h9, 4'hb: days_in = 5'h1e;
      default: days_in = 5'h1f;
    endcase
  endfunction : days_in

  // one minute forward with carries through the calendar
  function automatic dstcv_pkg::dstcv_time_t advance(
      input dstcv_pkg::dstcv_time_t t);
    dstcv_pkg::dstcv_time_t a;
    a = t;
    if (t.minute != 6'h3b) begin
      a.minute = t.minute + 6'h01;
    end else begin
      a.minute = 6'h00;
      if (t.hour != 5'h17) begin
        a.hour = t.hour + 5'h01;
      end else begin
        a.hour = 5'h00;
        a.wday = (t.wday == dstcv_pkg::WDAY_SATURDAY) ?
                 dstcv_pkg::WDAY_SUNDAY : t.wday + 3'h1;
        if (t.day < days_in(t.month, t.year)) begin
          a.day = t.day + 5'h01;
        end else begin
          a.day = 5'h01;
          if (t.month != 4'hc) begin
            a.month = t.month + 4'h1;
          end else begin
            a.month = 4'h1;
            a.year = (t.year == 7'h63) ? 7'h00 : t.year + 7'h01;
          end
        end
      end
    end
    return a;
  endfunction : advance

  // transition instant: on the hour, right month, right Sunday or date
  function automatic logic hit(input dstcv_pkg::dstcv_time_t t,
                               input dstcv_pkg::dstcv_rule_t r);
    logic day_ok;
    day_ok = 1'b0;
    case (r.kind)
      dstcv_pkg::wk_first: day_ok = t.day <= 5'h07;
      dstcv_pkg::wk_second: day_ok = t.day >= 5'h08 && t.day <= 5'h0e;
      dstcv_pkg::wk_third: day_ok = t.day >= 5'h0f && t.day <= 5'h15;
      dstcv_pkg::wk_last:
        day_ok = 6'(t.day) + 6'h07 > 6'(days_in(t.month, t.year));
      default: day_ok = 1'b0;
    endcase
    if (r.kind != dstcv_pkg::wk_date) begin
      day_ok = day_ok && t.wday == dstcv_pkg::WDAY_SUNDAY;
    end else begin
      day_ok = t.day == r.day;
    end
    return day_ok && t.month == r.month && t.hour == r.hour &&
           t.minute == 6'h00;
  endfunction : hit

  // shift the time of day; step sizes never cross midnight
  function automatic dstcv_pkg::dstcv_time_t shift(
      input dstcv_pkg::dstcv_time_t t, input logic [7:0] d,
      input logic fwd);
    dstcv_pkg::dstcv_time_t a;
    logic [10:0] tot;
    a = t;
    tot = 11'(t.hour) * dstcv_pkg::MIN_PER_HOUR + 11'(t.minute);
    tot = fwd ? tot + 11'(d) : tot - 11'(d);
    a.hour = 5'(tot / dstcv_pkg::MIN_PER_HOUR);
    a.minute = 6'(tot % dstcv_pkg::MIN_PER_HOUR);
    return a;
  endfunction : shift

  function automatic logic [31:0] rd(input logic [7:0] addr);
    rd = 32'h0000_0000;
    case (addr)
      dstcv_pkg::REG_CTRL: begin
        rd[dstcv_pkg::CTRL_EN_BIT] = s_reg.conv_en;
        rd[dstcv_pkg::CTRL_PRESET_LSB +: 3] = s_reg.preset;
        rd[dstcv_pkg::CTRL_SYNC_BIT] = s_reg.sync_en;
      end
      dstcv_pkg::REG_USER_START: begin
        rd[dstcv_pkg::UDATE_MONTH_LSB +: 4] = s_reg.us_month;
        rd[dstcv_pkg::UDATE_DAY_LSB +: 5] = s_reg.us_day;
      end
      dstcv_pkg::REG_USER_END: begin
        rd[dstcv_pkg::UDATE_MONTH_LSB +: 4] = s_reg.ue_month;
        rd[dstcv_pkg::UDATE_DAY_LSB +: 5] = s_reg.ue_day;
      end
      dstcv_pkg::REG_USER_DELTA: rd[7:0] = s_reg.delta;
      dstcv_pkg::REG_TIME: begin
        rd[dstcv_pkg::TIME_MIN_LSB +: 6] = s_reg.t.minute;
        rd[dstcv_pkg::TIME_HOUR_LSB +: 5] = s_reg.t.hour;
        rd[dstcv_pkg::TIME_DAY_LSB +: 5] = s_reg.t.day;
        rd[dstcv_pkg::TIME_MONTH_LSB +: 4] = s_reg.t.month;
      end
      dstcv_pkg::REG_DATE: begin
        rd[dstcv_pkg::DATE_YEAR_LSB +: 7] = s_reg.t.year;
        rd[dstcv_pkg::DATE_WDAY_LSB +: 3] = s_reg.t.wday;
        rd[dstcv_pkg::DATE_SUMMER_BIT] = s_reg.summer;
      end
      default: rd = 32'h0000_0000;
    endcase
  endfunction : rd

  function automatic logic mapped(input logic [7:0] addr);
    return addr <= dstcv_pkg::REG_DATE && addr[1:0] == 2'h0;
  endfunction : mapped

  dstcv_pkg::dstcv_rule_t r_fwd;
  dstcv_pkg::dstcv_rule_t r_back;
  dstcv_pkg::dstcv_time_t base;
  logic [7:0] step;
  logic [31:0] wd;
  logic [31:0] cur;
  logic changed;

  always_comb begin
    s_next = s_reg;
    s_next.bcast = 1'b0;
    changed = 1'b0;
    wd = 32'h0000_0000;
    cur = 32'h0000_0000;
    r_fwd = '{dstcv_pkg::MON_MAR, dstcv_pkg::wk_last, 5'h00,
              dstcv_pkg::HOUR_2};
    r_back = '{dstcv_pkg::MON_OCT, dstcv_pkg::wk_last, 5'h00,
               dstcv_pkg::HOUR_3};
    case (s_reg.preset)
      dstcv_pkg::preset_britain: begin
        r_fwd.hour = dstcv_pkg::HOUR_1;
        r_back.hour = dstcv_pkg::HOUR_2;
      end
      dstcv_pkg::preset_america_old: begin
        r_fwd.month = dstcv_pkg::MON_APR;
        r_fwd.kind = dstcv_pkg::wk_first;
        r_back.hour = dstcv_pkg::HOUR_2;
      end
      dstcv_pkg::preset_america_new: begin
        r_fwd.kind = dstcv_pkg::wk_second;
        r_back = '{dstcv_pkg::MON_NOV, dstcv_pkg::wk_first, 5'h00,
                   dstcv_pkg::HOUR_2};
      end
      dstcv_pkg::preset_australia: begin
        r_fwd.month = dstcv_pkg::MON_OCT;
        r_back.month = dstcv_pkg::MON_MAR;
      end
      dstcv_pkg::preset_tasmania: begin
        r_fwd.month = dstcv_pkg::MON_OCT;
        r_fwd.kind = dstcv_pkg::wk_first;
        r_back.month = dstcv_pkg::MON_MAR;
      end
      dstcv_pkg::preset_new_zealand: begin
        r_fwd.month = dstcv_pkg::MON_OCT;
        r_fwd.kind = dstcv_pkg::wk_first;
        r_back.month = dstcv_pkg::MON_MAR;
        r_back.kind = dstcv_pkg::wk_third;
      end
      dstcv_pkg::preset_user: begin
        r_fwd = '{s_reg.us_month, dstcv_pkg::wk_date, s_reg.us_day,
                  dstcv_pkg::HOUR_2};
        r_back = '{s_reg.ue_month, dstcv_pkg::wk_date, s_reg.ue_day,
                   dstcv_pkg::HOUR_3};
      end
      default: ;
    endcase
    step = (s_reg.preset == dstcv_pkg::preset_user) ?
           s_reg.delta : dstcv_pkg::PRESET_DELTA_MIN;

    // minute clock keeps running on backup, only conversion and the hourly broadcast pause
    base = s_reg.t;
    if (s_reg.presc == TICKS_PER_MIN - 1) begin
      s_next.presc = 32'h0000_0000;
      base = advance(s_reg.t);
      if (base.minute == 6'h00 && op_active) begin
        changed = 1'b1;
      end
    end else begin
      s_next.presc = s_reg.presc + 32'h0000_0001;
    end
    s_next.t = base;

    // summer flag arms one direction at a time, so the repeated hour
    // after a backward step cannot fire again
    if (s_reg.conv_en && op_active) begin
      if (!s_reg.summer && hit(base, r_fwd)) begin
        s_next.t = shift(base, step, 1'b1);
        s_next.summer = 1'b1;
        changed = 1'b1;
      end else if (s_reg.summer && hit(base, r_back)) begin
        s_next.t = shift(base, step, 1'b0);
        s_next.summer = 1'b0;
        changed = 1'b1;
      end
    end

    if (sync_valid && s_reg.sync_en) begin
      s_next.t = '{sync_year, sync_month, sync_day, sync_wday, sync_hour,
                   sync_minute};
    end

    // read channel
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rd(s_axi_araddr);
      s_next.rresp = mapped(s_axi_araddr) ? dstcv_pkg::RESP_OKAY :
                     dstcv_pkg::RESP_SLVERR;
    end
    s_next.arready = !s_next.rvalid;

    // write channels, taken in either order
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.aw_have = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.w_have = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    if (s_next.aw_have && s_next.w_have && !s_reg.bvalid) begin
      s_next.aw_have = 1'b0;
      s_next.w_have = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = mapped(s_next.aw_addr) ? dstcv_pkg::RESP_OKAY :
                     dstcv_pkg::RESP_SLVERR;
      cur = rd(s_next.aw_addr);
      for (int i = 0; i < 4; i++) begin
        wd[i*8 +: 8] = s_next.wstrb[i] ? s_next.wdata[i*8 +: 8] :
                       cur[i*8 +: 8];
      end
      case (s_next.aw_addr)
        dstcv_pkg::REG_CTRL: begin
          // outside programming/parameter mode the write is dropped
          if (cfg_allowed) begin
            s_next.conv_en = wd[dstcv_pkg::CTRL_EN_BIT];
            s_next.preset = dstcv_pkg::dstcv_preset_t'(
                wd[dstcv_pkg::CTRL_PRESET_LSB +: 3]);
            s_next.sync_en = wd[dstcv_pkg::CTRL_SYNC_BIT];
          end
        end
        dstcv_pkg::REG_USER_START: begin
          s_next.us_month = wd[dstcv_pkg::UDATE_MONTH_LSB +: 4];
          s_next.us_day = wd[dstcv_pkg::UDATE_DAY_LSB +: 5];
        end
        dstcv_pkg::REG_USER_END: begin
          s_next.ue_month = wd[dstcv_pkg::UDATE_MONTH_LSB +: 4];
          s_next.ue_day = wd[dstcv_pkg::UDATE_DAY_LSB +: 5];
        end
        dstcv_pkg::REG_USER_DELTA: begin
          if (wd[31:8] == 24'h00_0000 &&
              wd[7:0] <= dstcv_pkg::DELTA_MAX_MIN) begin
            s_next.delta = wd[7:0];
          end
        end
        dstcv_pkg::REG_TIME: begin
          s_next.t.minute = wd[dstcv_pkg::TIME_MIN_LSB +: 6];
          s_next.t.hour = wd[dstcv_pkg::TIME_HOUR_LSB +: 5];
          s_next.t.day = wd[dstcv_pkg::TIME_DAY_LSB +: 5];
          s_next.t.month = wd[dstcv_pkg::TIME_MONTH_LSB +: 4];
          s_next.presc = 32'h0000_0000;
          changed = 1'b1;
        end
        dstcv_pkg::REG_DATE: begin
          s_next.t.year = wd[dstcv_pkg::DATE_YEAR_LSB +: 7];
          s_next.t.wday = wd[dstcv_pkg::DATE_WDAY_LSB +: 3];
          changed = 1'b1;
        end
        default: ;
      endcase
    end
    s_next.awready = !s_next.aw_have && !s_next.bvalid;
    s_next.wready = !s_next.w_have && !s_next.bvalid;

    if (!s_reg.booted) begin
      s_next.booted = 1'b1;
      changed = 1'b1;
    end
    if (changed) begin
      s_next.bcast = 1'b1;
      s_next.bt = s_next.t;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.t.day <= dstcv_pkg::RST_DAY;
      s_reg.t.month <= dstcv_pkg::RST_MONTH;
      s_reg.bt.day <= dstcv_pkg::RST_DAY;
      s_reg.bt.month <= dstcv_pkg::RST_MONTH;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign bcast_valid = s_reg.bcast;
  assign bcast_year = s_reg.bt.year;
  assign bcast_month = s_reg.bt.month;
  assign bcast_day = s_reg.bt.day;
  assign bcast_wday = s_reg.bt.wday;
  assign bcast_hour = s_reg.bt.hour;
  assign bcast_minute = s_reg.bt.minute;
  assign summer_active = s_reg.summer;

endmodule : dstcv_top

`default_nettype wire

// file: logic/dstcv_pkg.sv
package dstcv_pkg;

  // register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_USER_START = 8'h04;
  localparam logic [7:0] REG_USER_END = 8'h08;
  localparam logic [7:0] REG_USER_DELTA = 8'h0c;
  localparam logic [7:0] REG_TIME = 8'h10;
  localparam logic [7:0] REG_DATE = 8'h14;

  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PRESET_LSB = 1;
  localparam int CTRL_SYNC_BIT = 4;
  localparam int UDATE_MONTH_LSB = 0;
  localparam int UDATE_DAY_LSB = 8;
  localparam int TIME_MIN_LSB = 0;
  localparam int TIME_HOUR_LSB = 8;
  localparam int TIME_DAY_LSB = 16;
  localparam int TIME_MONTH_LSB = 24;
  localparam int DATE_YEAR_LSB = 0;
  localparam int DATE_WDAY_LSB = 8;
  localparam int DATE_SUMMER_BIT = 16;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // reset values
  localparam logic [4:0] RST_DAY = 5'h01;
  localparam logic [3:0] RST_MONTH = 4'h1;

  // conversion figures
  localparam logic [7:0] DELTA_MAX_MIN = 8'hb4;
  localparam logic [7:0] PRESET_DELTA_MIN = 8'h3c;
  localparam logic [3:0] MON_MAR = 4'h3;
  localparam logic [3:0] MON_APR = 4'h4;
  localparam logic [3:0] MON_OCT = 4'ha;
  localparam logic [3:0] MON_NOV = 4'hb;
  localparam logic [4:0] HOUR_1 = 5'h01;
  localparam logic [4:0] HOUR_2 = 5'h02;
  localparam logic [4:0] HOUR_3 = 5'h03;
  localparam logic [2:0] WDAY_SUNDAY = 3'h0;
  localparam logic [2:0] WDAY_SATURDAY = 3'h6;
  localparam logic [10:0] MIN_PER_HOUR = 11'h03c;

  // timing: one minute of the time-of-day clock
  localparam longint unsigned CLK_HZ = 40000000;
  localparam longint unsigned MINUTE_S = 60;
  localparam longint unsigned TICKS_PER_MIN = CLK_HZ * MINUTE_S;

  typedef enum logic [2:0] {
    preset_europe,
    preset_britain,
    preset_america_old,
    preset_america_new,
    preset_australia,
    preset_tasmania,
    preset_new_zealand,
    preset_user
  } dstcv_preset_t;

  typedef enum logic [2:0] {
    wk_first, wk_second, wk_third, wk_last, wk_date
  } dstcv_week_t;

  typedef struct packed {
    logic [3:0] month;
    dstcv_week_t kind;
    logic [4:0] day;
    logic [4:0] hour;
  } dstcv_rule_t;

  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [2:0] wday;
    logic [4:0] hour;
    logic [5:0] minute;
  } dstcv_time_t;

endpackage : dstcv_pkg

// file: sim/dstcv_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dstcv_top_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic op_active,
  input wire logic bcast_valid,
  input wire logic [4:0] bcast_hour,
  input wire logic summer_active
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_PWRUP_BCAST: assert property ($rose(aresetn) |=> bcast_valid)
    else $error("no broadcast after reset release");
  AST_RESET_OFF: assert property ($rose(aresetn) |-> !summer_active)
    else $error("summer flag set out of reset");
  // the past-reset guard keeps a one-edge reset from looking like a step
  AST_CONV_POWERED: assert property (
    $past(aresetn) && $changed(summer_active) |-> $past(op_active))
    else $error("conversion while on backup");
  AST_CONV_BCAST: assert property (
    $past(aresetn) && $changed(summer_active) |-> bcast_valid)
    else $error("conversion without broadcast");
  AST_BCAST_HOLD: assert property (
    $past(aresetn) && !bcast_valid |-> $stable(bcast_hour))
    else $error("broadcast time moved without a pulse");
  AST_WR_ANSWER: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write not answered");
  AST_WR_RELEASE: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1
    s_axi_awready && s_axi_wready)
    else $error("write channel not reopened");
  AST_RD_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  AST_RD_RELEASE: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not reopened");
endmodule : dstcv_top_sva

bind dstcv_top dstcv_top_sva u_sva (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .op_active, .bcast_valid,
  .bcast_hour, .summer_active
);
`default_nettype wire

// file: sim/dstcv_partner.sv
`timescale 1ns/1ps
`default_nettype none
module dstcv_partner (
  input wire logic aclk,
  output logic sync_valid,
  output logic [6:0] sync_year,
  output logic [3:0] sync_month,
  output logic [4:0] sync_day,
  output logic [2:0] sync_wday,
  output logic [4:0] sync_hour,
  output logic [5:0] sync_minute,
  input wire logic bcast_valid,
  input wire logic [6:0] bcast_year,
  input wire logic [3:0] bcast_month,
  input wire logic [4:0] bcast_day,
  input wire logic [2:0] bcast_wday,
  input wire logic [4:0] bcast_hour,
  input wire logic [5:0] bcast_minute
);
  dstcv_pkg::dstcv_time_t drv = '0;
  dstcv_pkg::dstcv_time_t last_t = '0;
  int n_bcast = 0;
  initial sync_valid = 1'b0;
  assign {sync_year, sync_month, sync_day, sync_wday, sync_hour,
    sync_minute} = drv;
  // expansion side keeps the last time it was sent
  always @(posedge aclk) begin
    if (bcast_valid === 1'b1) begin
      last_t <= {bcast_year, bcast_month, bcast_day, bcast_wday, bcast_hour,
        bcast_minute};
      n_bcast <= n_bcast + 1;
    end
  end
  // a time source is attached, so enabling sync is legal here
  task automatic send_sync(input logic [3:0] mo, input logic [4:0] d,
      input logic [4:0] h, input logic [5:0] mi);
    @(posedge aclk);
    drv <= {7'h00, mo, d, 3'h0, h, mi};
    sync_valid <= 1'b1;
    @(posedge aclk);
    sync_valid <= 1'b0;
    // released lines carry no stale time
    drv <= ~{7'h00, mo, d, 3'h0, h, mi};
  endtask : send_sync
endmodule : dstcv_partner
`default_nettype wire

// file: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int unsigned TPM = 8;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic op_active = 1'b1, cfg_allowed = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sync_valid, bcast_valid, summer_active;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [6:0] sync_year, bcast_year;
  logic [3:0] sync_month, bcast_month;
  logic [4:0] sync_day, bcast_day, sync_hour, bcast_hour;
  logic [2:0] sync_wday, bcast_wday;
  logic [5:0] sync_minute, bcast_minute;
  int n_fail = 0;
  int n_tests = 0;
  // per preset: start month, day, hour; end month, day, hour
  logic [31:0] tbl [7] = '{32'h31d2a1b3, 32'h31d1a1b2, 32'h4032a1b2,
    32'h30a2b022, 32'ha1b231d3, 32'ha04231d3, 32'ha0423113};

  always #12.5 aclk = ~aclk;

  dstcv_top #(.TICKS_PER_MIN(TPM)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .op_active, .cfg_allowed, .sync_valid, .sync_year, .sync_month,
    .sync_day, .sync_wday, .sync_hour, .sync_minute, .bcast_valid,
    .bcast_year, .bcast_month, .bcast_day, .bcast_wday, .bcast_hour,
    .bcast_minute, .summer_active
  );
  dstcv_partner u_part (
    .aclk, .sync_valid, .sync_year, .sync_month, .sync_day, .sync_wday,
    .sync_hour, .sync_minute, .bcast_valid, .bcast_year, .bcast_month,
    .bcast_day, .bcast_wday, .bcast_hour, .bcast_minute
  );

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  task automatic stall();
    n_fail++;
    $display("ERROR t=%0t wait expired got=%h exp=%h", $time, 1'b0, 1'b1);
    wrap_up();
  endtask : stall

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit bad);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (i == 40) stall();
    chk(32'(s_axi_bresp), bad ? 32'(dstcv_pkg::RESP_SLVERR) :
      32'(dstcv_pkg::RESP_OKAY));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e, input bit bad);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (i == 40) stall();
    chk(s_axi_rdata & m, e);
    chk(32'(s_axi_rresp), bad ? 32'(dstcv_pkg::RESP_SLVERR) :
      32'(dstcv_pkg::RESP_OKAY));
  endtask : rd

  task automatic set_t(input logic [3:0] mo, input logic [4:0] d,
      input logic [3:0] h, input logic [5:0] mi);
    wr(dstcv_pkg::REG_TIME, {4'h0, mo, 3'h0, d, 4'h0, h, 2'h0, mi}, 1'b0);
  endtask : set_t

  task automatic wait_sum(input logic v);
    int i;
    for (i = 0; i < 600 && summer_active !== v; i++) @(negedge aclk);
    if (i == 600) stall();
  endtask : wait_sum

  // first negedge lets a broadcast already under way settle, so it is not counted
  task automatic wait_bc();
    int i;
    int n0;
    @(negedge aclk);
    n0 = u_part.n_bcast;
    for (i = 0; i < 600 && u_part.n_bcast == n0; i++) @(negedge aclk);
    if (i == 600) stall();
  endtask : wait_bc

  task automatic t_reset();
    rd(dstcv_pkg::REG_CTRL, 32'hffffffff, 32'h0, 1'b0);
    rd(dstcv_pkg::REG_TIME, 32'h0f1f0000, 32'h01010000, 1'b0);
    wr(dstcv_pkg::REG_DATE, 32'h00000001, 1'b0);
    rd(dstcv_pkg::REG_DATE, 32'h0001077f, 32'h00000001, 1'b0);
    $display("reset values done");
  endtask : t_reset

  task automatic t_bus();
    rd(8'h18, 32'hffffffff, 32'h0, 1'b1);
    rd(8'h02, 32'hffffffff, 32'h0, 1'b1);
    wr(8'h1c, 32'h1, 1'b1);
    $display("unmapped access done");
  endtask : t_bus

  task automatic t_cfg();
    cfg_allowed <= 1'b0;
    wr(dstcv_pkg::REG_CTRL, 32'h11, 1'b0);
    rd(dstcv_pkg::REG_CTRL, 32'h1f, 32'h0, 1'b0);
    cfg_allowed <= 1'b1;
    wr(dstcv_pkg::REG_CTRL, 32'h11, 1'b0);
    rd(dstcv_pkg::REG_CTRL, 32'h1f, 32'h11, 1'b0);
    $display("config mode done");
  endtask : t_cfg

  task automatic t_off();
    wr(dstcv_pkg::REG_CTRL, 32'h0, 1'b0);
    set_t(4'h3, 5'h1d, 4'h1, 6'h3b);
    wait_bc();
    chk({summer_active, u_part.last_t},
      {1'b0, 7'h01, 4'h3, 5'h1d, 3'h0, 5'h02, 6'h00});
    $display("disabled conversion done");
  endtask : t_off

  task automatic t_backup();
    set_t(4'h3, 5'h1d, 4'h1, 6'h3b);
    wr(dstcv_pkg::REG_CTRL, 32'h1, 1'b0);
    op_active <= 1'b0;
    repeat (3 * TPM) @(posedge aclk);
    rd(dstcv_pkg::REG_DATE, 32'h00010000, 32'h0, 1'b0);
    rd(dstcv_pkg::REG_TIME, 32'h00001f00, 32'h00000200, 1'b0);
    op_active <= 1'b1;
    $display("backup operation done");
  endtask : t_backup

  task automatic t_sync();
    wr(dstcv_pkg::REG_CTRL, 32'h0, 1'b0);
    set_t(4'h5, 5'h09, 4'h5, 6'h00);
    u_part.send_sync(4'h6, 5'h0a, 5'h07, 6'h21);
    rd(dstcv_pkg::REG_TIME, 32'h0f1f1f00, 32'h05090500, 1'b0);
    wr(dstcv_pkg::REG_CTRL, 32'h10, 1'b0);
    u_part.send_sync(4'h6, 5'h0a, 5'h0b, 6'h21);
    rd(dstcv_pkg::REG_TIME, 32'h0f1f1f00, 32'h060a0b00, 1'b0);
    $display("time sync done");
  endtask : t_sync

  task automatic t_presets();
    logic [31:0] e;
    for (int p = 0; p < 7; p++) begin
      e = tbl[p];
      wr(dstcv_pkg::REG_CTRL, (p << 1) | 1, 1'b0);
      set_t(e[31:28], e[24:20], e[19:16] - 4'h1, 6'h3b);
      wait_sum(1'b1);
      chk({bcast_hour, bcast_minute}, {1'b0, e[19:16] + 4'h1, 6'h00});
      set_t(e[15:12], e[8:4], e[3:0] - 4'h1, 6'h3b);
      wait_sum(1'b0);
      chk({bcast_hour, bcast_minute}, {1'b0, e[3:0] - 4'h1, 6'h00});
      if (p == 0) begin
        wait_bc();
        chk({summer_active, u_part.last_t.hour}, {1'b0, 5'h03});
      end
    end
    // the two checks above also stand
    $display("presets done");
  endtask : t_presets

  task automatic t_user();
    wr(dstcv_pkg::REG_USER_DELTA, 32'hb4, 1'b0);
    wr(dstcv_pkg::REG_USER_DELTA, 32'hb5, 1'b0);
    rd(dstcv_pkg::REG_USER_DELTA, 32'hff, 32'hb4, 1'b0);
    wr(dstcv_pkg::REG_USER_DELTA, 32'h78, 1'b0);
    wr(dstcv_pkg::REG_USER_START, 32'h1f03, 1'b0);
    wr(dstcv_pkg::REG_USER_END, 32'h010b, 1'b0);
    wr(dstcv_pkg::REG_CTRL, 32'h0f, 1'b0);
    set_t(4'h3, 5'h1f, 4'h1, 6'h3b);
    wait_sum(1'b1);
    chk({bcast_hour, bcast_minute}, {5'h04, 6'h00});
    set_t(4'hb, 5'h01, 4'h2, 6'h3b);
    wait_sum(1'b0);
    chk({bcast_hour, bcast_minute}, {5'h01, 6'h00});
    $display("user rule done");
  endtask : t_user

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_bus();
    t_cfg();
    t_off();
    t_backup();
    t_sync();
    t_presets();
    t_user();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    stall();
  end
endmodule : testbench
`default_nettype wire
